// ### hdl/rtc_locked_indirect_register_port.sv
// locked indirect register port of the low-power clock: key lock, address, data
// assumes one-cycle read/write strobes from the processor on core_clk
module rtc_locked_indirect_register_port
	import rtc_port_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [1:0]  bus_sel,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	output logic             bus_rvalid,
	output logic      [31:0] timer_capture,
	output logic             capture_load,
	output logic      [7:0]  clock_state_control,
	output logic      [7:0]  oscillator_control,
	output logic      [7:0]  oscillator_configuration,
	output logic      [7:0]  pin_configuration,
	output logic      [31:0] alarm_value,
	output logic      [1:0]  lock_state
);
	import rtc_port_pkg::*;

	lock_state_t lock_q;
	logic [7:0]  addr_q;
	logic [7:0]  rdata_q;
	logic        rvalid_q;
	logic [7:0]  capture_q [4];
	logic [7:0]  alarm_q [4];
	logic [7:0]  state_ctrl_q;
	logic [7:0]  osc_ctrl_q;
	logic [7:0]  osc_cfg_q;
	logic [7:0]  pin_cfg_q;
	logic        load_q;

	logic        key_wr;
	logic        addr_wr;
	logic        idx_access;
	logic        port_open;
	logic        data_wr;
	logic        wr_state_ctrl;
	logic        wr_osc_ctrl;
	logic        wr_osc_cfg;
	logic        wr_pin_cfg;
	logic        in_capture;
	logic        in_alarm;
	logic [7:0]  ind_rdata;
	logic [7:0]  key_status;

	// ------------------------------------------------------------
	// strobe decode
	// ------------------------------------------------------------
	assign port_open  = lock_q == LOCK_OPEN;
	assign key_wr     = bus_wr && bus_sel == SEL_KEY;
	// address or data access; key reads are not indirect accesses
	assign idx_access = (bus_wr || bus_rd) && (bus_sel == SEL_ADDR || bus_sel == SEL_DATA);
	assign addr_wr    = bus_wr && bus_sel == SEL_ADDR && port_open;
	assign data_wr    = bus_wr && bus_sel == SEL_DATA && port_open;

	// per-register write enables; an unmapped address raises none of them
	assign wr_state_ctrl = data_wr && addr_q == ADDR_STATE_CTRL;
	assign wr_osc_ctrl   = data_wr && addr_q == ADDR_OSC_CTRL;
	assign wr_osc_cfg    = data_wr && addr_q == ADDR_OSC_CFG;
	assign wr_pin_cfg    = data_wr && addr_q == ADDR_PIN_CFG;

	// byte windows of the two multi-byte registers
	assign in_capture = addr_q <= ADDR_CAPTURE3;
	assign in_alarm   = addr_q >= ADDR_ALARM0 && addr_q <= ADDR_ALARM3;

	// ------------------------------------------------------------
	// lock state machine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			lock_q <= LOCK_IDLE;
		end else begin
			case (lock_q)
				LOCK_IDLE: begin
					if (idx_access) begin
						lock_q <= LOCK_DISABLED;
					end else if (key_wr) begin
						lock_q <= (bus_wdata == KEY_FIRST) ? LOCK_HALF : LOCK_DISABLED;
					end
				end
				LOCK_HALF: begin
					// no timeout: the state waits indefinitely for the second key
					if (idx_access) begin
						lock_q <= LOCK_DISABLED;
					end else if (key_wr) begin
						lock_q <= (bus_wdata == KEY_SECOND) ? LOCK_OPEN : LOCK_DISABLED;
					end
				end
				LOCK_OPEN: begin
					if (key_wr) begin
						lock_q <= LOCK_IDLE;
					end
				end
				LOCK_DISABLED: begin
					// only a system reset leaves this state; key writes are ignored here
					lock_q <= LOCK_DISABLED;
				end
				default: begin
					lock_q <= LOCK_DISABLED;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// indirect address
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_q <= 8'h00;
		end else if (addr_wr) begin
			// kept across a relock, so a fresh unlock resumes at the last address
			addr_q <= bus_wdata;
		end
	end

	// ------------------------------------------------------------
	// internal registers
	// ------------------------------------------------------------
	// one loop serves both four-byte registers; byte n sits at its base address plus n
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_bytes
			always_ff @(posedge core_clk) begin
				if (reset) begin
					capture_q[g] <= RESET_BYTE;
					alarm_q[g]   <= RESET_BYTE;
				end else if (data_wr) begin
					if (addr_q == ADDR_CAPTURE0 + 8'(g)) begin
						capture_q[g] <= bus_wdata;
					end
					if (addr_q == ADDR_ALARM0 + 8'(g)) begin
						alarm_q[g] <= bus_wdata;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// control and configuration bytes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ctrl_q <= RESET_BYTE;
		end else if (wr_state_ctrl) begin
			state_ctrl_q <= bus_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			osc_ctrl_q <= RESET_BYTE;
		end else if (wr_osc_ctrl) begin
			osc_ctrl_q <= bus_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			osc_cfg_q <= RESET_BYTE;
		end else if (wr_osc_cfg) begin
			osc_cfg_q <= bus_wdata;
		end
	end

	// reserved bits hold their value whatever software writes, so a careless
	// read-modify-write cannot disturb them
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_cfg_q <= PIN_CFG_RESET;
		end else if (wr_pin_cfg) begin
			pin_cfg_q <= (pin_cfg_q & ~PIN_CFG_WMASK) | (bus_wdata & PIN_CFG_WMASK);
		end
	end

	// ------------------------------------------------------------
	// timer load pulse
	// ------------------------------------------------------------
	// pulse after a write to the top capture byte so the timer takes all four bytes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			load_q <= 1'b0;
		end else begin
			load_q <= data_wr && addr_q == ADDR_CAPTURE3;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		ind_rdata = 8'h00;
		if (in_capture) begin
			ind_rdata = capture_q[addr_q[1:0]];
		end else if (in_alarm) begin
			ind_rdata = alarm_q[addr_q[1:0]];
		end else begin
			case (addr_q)
				ADDR_STATE_CTRL: begin
					ind_rdata = state_ctrl_q;
				end
				ADDR_OSC_CTRL: begin
					ind_rdata = osc_ctrl_q;
				end
				ADDR_OSC_CFG: begin
					ind_rdata = osc_cfg_q;
				end
				ADDR_PIN_CFG: begin
					ind_rdata = pin_cfg_q;
				end
				default: begin
					ind_rdata = 8'h00;
				end
			endcase
		end
	end

	// lock status code; reading it has no effect on the lock state machine
	always_comb begin
		key_status = STATUS_DISABLED;
		case (lock_q)
			LOCK_IDLE: begin
				key_status = STATUS_IDLE;
			end
			LOCK_HALF: begin
				key_status = STATUS_HALF;
			end
			LOCK_OPEN: begin
				key_status = STATUS_OPEN;
			end
			default: begin
				key_status = STATUS_DISABLED;
			end
		endcase
	end

	// read data is held until the next read so a slow processor may fetch it late
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (bus_rd) begin
			case (bus_sel)
				SEL_KEY: begin
					rdata_q <= key_status;
				end
				SEL_ADDR: begin
					rdata_q <= port_open ? addr_q : 8'h00;
				end
				SEL_DATA: begin
					rdata_q <= port_open ? ind_rdata : 8'h00;
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= bus_rd;
		end
	end

	assign bus_rdata                = rdata_q;
	assign bus_rvalid               = rvalid_q;
	assign timer_capture            = {capture_q[3], capture_q[2], capture_q[1], capture_q[0]};
	assign capture_load             = load_q;
	assign clock_state_control      = state_ctrl_q;
	assign oscillator_control       = osc_ctrl_q;
	assign oscillator_configuration = osc_cfg_q;
	assign pin_configuration        = pin_cfg_q;
	assign alarm_value              = {alarm_q[3], alarm_q[2], alarm_q[1], alarm_q[0]};
	assign lock_state               = lock_q;

endmodule : rtc_locked_indirect_register_port

// ### hdl/rtc_port_pkg.sv
// constants for the locked indirect register port of the low-power clock
// assumes a byte-wide processor register interface on one system clock
package rtc_port_pkg;

	// ------------------------------------------------------------
	// processor-visible port selectors
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_KEY  = 2'h0;
	localparam logic [1:0] SEL_ADDR = 2'h1;
	localparam logic [1:0] SEL_DATA = 2'h2;

	// ------------------------------------------------------------
	// internal register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CAPTURE0   = 8'h00;
	localparam logic [7:0] ADDR_CAPTURE3   = 8'h03;
	localparam logic [7:0] ADDR_STATE_CTRL = 8'h04;
	localparam logic [7:0] ADDR_OSC_CTRL   = 8'h05;
	localparam logic [7:0] ADDR_OSC_CFG    = 8'h06;
	localparam logic [7:0] ADDR_PIN_CFG    = 8'h07;
	localparam logic [7:0] ADDR_ALARM0     = 8'h08;
	localparam logic [7:0] ADDR_ALARM3     = 8'h0b;

	// ------------------------------------------------------------
	// reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE      = 8'h00;
	localparam logic [7:0] PIN_CFG_RESET   = 8'h00;
	localparam int         PIN_SHORT_BIT   = 7;
	localparam logic [7:0] PIN_CFG_WMASK   = 8'h80;

	// ------------------------------------------------------------
	// unlock keys and status codes
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST  = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;

	typedef enum logic [1:0] {
		LOCK_IDLE     = 2'b00,
		LOCK_HALF     = 2'b01,
		LOCK_OPEN     = 2'b10,
		LOCK_DISABLED = 2'b11
	} lock_state_t;

	localparam logic [7:0] STATUS_IDLE     = 8'h00;
	localparam logic [7:0] STATUS_HALF     = 8'h01;
	localparam logic [7:0] STATUS_OPEN     = 8'h02;
	localparam logic [7:0] STATUS_DISABLED = 8'h03;

endpackage : rtc_port_pkg

// ### tb/rtc_port_assertions.sv
// concurrent checks for the locked indirect register port
// assumes it is bound onto the port module and sees only its ports
module rtc_port_checker
	import rtc_port_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [1:0] bus_sel,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic       bus_rvalid,
	input wire logic [7:0] pin_configuration,
	input wire logic [1:0] lock_state
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic kw;
	logic use_lk;
	assign kw = bus_wr && bus_sel == SEL_KEY;
	assign use_lk = (bus_wr || bus_rd) && (bus_sel == SEL_ADDR || bus_sel == SEL_DATA) && lock_state != LOCK_OPEN;
	AST_RVALID: assert property (bus_rd |=> bus_rvalid) else $error("read not answered");
	AST_FIRST_KEY: assert property (kw && lock_state == LOCK_IDLE && bus_wdata == KEY_FIRST |=>
		lock_state == LOCK_HALF) else $error("first key not taken");
	AST_SECOND_KEY: assert property (kw && lock_state == LOCK_HALF && bus_wdata == KEY_SECOND |=>
		lock_state == LOCK_OPEN) else $error("second key not taken");
	AST_BAD_FIRST: assert property (kw && lock_state == LOCK_IDLE && bus_wdata != KEY_FIRST |=>
		lock_state == LOCK_DISABLED) else $error("bad first key accepted");
	AST_BAD_SECOND: assert property (kw && lock_state == LOCK_HALF && bus_wdata != KEY_SECOND |=>
		lock_state == LOCK_DISABLED) else $error("bad key accepted");
	AST_LOCKED_USE: assert property (use_lk |=> lock_state == LOCK_DISABLED) else $error("locked use");
	AST_STICKY: assert property (lock_state == LOCK_DISABLED |=> lock_state == LOCK_DISABLED) else $error("left");
	AST_RELOCK: assert property (kw && lock_state == LOCK_OPEN |=> lock_state == LOCK_IDLE) else $error("no relock");
	AST_KEY_READ: assert property (bus_rd && bus_sel == SEL_KEY |=>
		$stable(lock_state) && bus_rdata == {6'h00, lock_state}) else $error("key read wrong");
	AST_WAIT: assert property (lock_state == LOCK_HALF && !bus_wr && !bus_rd |=>
		lock_state == LOCK_HALF) else $error("half state lost");
	AST_PIN_RSVD: assert property (pin_configuration[6:0] == 7'h00) else $error("reserved bits moved");
	cover property (lock_state == LOCK_HALF ##1 lock_state == LOCK_OPEN);
	cover property (kw && lock_state == LOCK_OPEN);
	cover property (use_lk);
endmodule : rtc_port_checker

bind rtc_locked_indirect_register_port rtc_port_checker u_chk (.core_clk, .reset, .bus_wr, .bus_rd, .bus_sel,
	.bus_wdata, .bus_rdata, .bus_rvalid, .pin_configuration, .lock_state);

// ### tb/test_rtc_locked_indirect_register_port.sv
// self-checking bench for the locked indirect register port
// assumes the package, the port module and its checker are compiled first
module test_rtc_locked_indirect_register_port;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_port_pkg::*;
	logic        core_clk = 0, reset = 1, bus_wr = 0, bus_rd = 0, rvalid, cload;
	logic [1:0]  bus_sel = 2'h0, lock;
	logic [7:0]  bus_wdata = 8'h00, rdata, ctl, xctl, xcfg, pin, got;
	logic [31:0] tcap, alarm;
	int          errors = 0, n_checks = 0, cycles = 0;
	rtc_locked_indirect_register_port dut (.core_clk, .reset, .bus_wr, .bus_rd, .bus_sel, .bus_wdata,
		.bus_rdata(rdata), .bus_rvalid(rvalid), .timer_capture(tcap), .capture_load(cload),
		.clock_state_control(ctl), .oscillator_control(xctl), .oscillator_configuration(xcfg),
		.pin_configuration(pin), .alarm_value(alarm), .lock_state(lock));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// one idle cycle between requests keeps each strobe a single assignment per step
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge core_clk);
		#1 bus_wr = 1'b1;
		bus_sel = s;
		bus_wdata = d;
		@(posedge core_clk);
		#1 bus_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(posedge core_clk);
		#1 bus_rd = 1'b1;
		bus_sel = s;
		@(posedge core_clk);
		#1 bus_rd = 1'b0;
		// rvalid stands only until the next edge, so it is taken right after the read edge
		chk("rvalid", 32'h1, {31'h0, rvalid});
		d = rdata;
	endtask : rd
	task automatic rk(input logic [7:0] exp);
		rd(SEL_KEY, got);
		chk("key status", {24'h0, exp}, {24'h0, got});
	endtask : rk
	task automatic rst(input int n);
		reset = 1'b1;
		repeat (n) @(posedge core_clk);
		#1 reset = 1'b0;
	endtask : rst
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		rst(12);
		rk(STATUS_IDLE);
		wr(SEL_KEY, KEY_FIRST);
		rk(STATUS_HALF);
		repeat (40) @(posedge core_clk);
		wr(SEL_KEY, KEY_SECOND);
		rk(STATUS_OPEN);
		chk("lock_state", {30'h0, LOCK_OPEN}, {30'h0, lock});
		// address 0x0c lies past the map and must leave every register alone
		for (int a = 0; a < 13; a++) begin
			wr(SEL_ADDR, 8'(a));
			wr(SEL_DATA, 8'h80 | 8'(a));
			chk("capture_load", {31'h0, a == 3}, {31'h0, cload});
		end
		for (int a = 0; a < 12; a++) begin
			wr(SEL_ADDR, 8'(a));
			rd(SEL_DATA, got);
			chk("indirect data", (a == 7) ? 32'h80 : (32'h80 | a), {24'h0, got});
		end
		chk("timer", 32'h83828180, tcap);
		chk("alarm", 32'h8b8a8988, alarm);
		chk("controls", 32'h80868584, {pin, xcfg, xctl, ctl});
		rd(SEL_ADDR, got);
		chk("address readback", 32'h0b, {24'h0, got});
		wr(SEL_ADDR, 8'h0c);
		rd(SEL_DATA, got);
		chk("unmapped address", 32'h0, {24'h0, got});
		wr(2'h3, 8'h5a);
		rd(2'h3, got);
		chk("unmapped select", 32'h0, {24'h0, got});
		wr(SEL_KEY, 8'h00);
		rk(STATUS_IDLE);
		for (int m = 0; m < 5; m++) begin
			rst(2);
			case (m)
				0: wr(SEL_KEY, 8'h5a);
				1: wr(SEL_KEY, KEY_SECOND);
				2: begin
					wr(SEL_KEY, KEY_FIRST);
					wr(SEL_KEY, KEY_FIRST);
				end
				3: rd(SEL_DATA, got);
				default: wr(SEL_ADDR, 8'h08);
			endcase
			if (m == 3) chk("locked read", 32'h0, {24'h0, got});
			rk(STATUS_DISABLED);
			chk("lock_state", {30'h0, LOCK_DISABLED}, {30'h0, lock});
			wr(SEL_KEY, KEY_FIRST);
			wr(SEL_KEY, KEY_SECOND);
			wr(SEL_ADDR, 8'h08);
			wr(SEL_DATA, 8'h11);
			rk(STATUS_DISABLED);
			chk("alarm after misuse", 32'h0, alarm);
		end
		give_verdict();
	end
endmodule : test_rtc_locked_indirect_register_port
